// ### verilog/mrs_slave.v
// Serial register-access slave: decodes requests, builds replies
`timescale 1ns/1ps
`default_nettype none
`include "mrs_consts.vh"
module mrs_slave (
   input wire core_clk_in,
   input wire rstn_in,
   input wire [7:0] slave_addr_in,
   input wire [15:0] vout_disp_in,
   input wire [15:0] iout_disp_in,
   input wire [7:0] rx_data_in,
   input wire rx_valid_in,
   input wire rx_frame_end_in,
   output reg rx_ready_out,
   output reg [7:0] tx_data_out,
   output reg tx_valid_out,
   input wire tx_ready_in,
   output reg tx_last_out,
   output reg [15:0] vset_out,
   output reg [15:0] iset_out
);
   localparam S_RX = 3'd0;
   localparam S_CHK = 3'd1;
   localparam S_HDR = 3'd2;
   localparam S_CRC = 3'd3;
   localparam S_DROP = 3'd4;

   function [15:0] crc_byte;
      input [15:0] c;
      input [7:0] d;
      integer k;
      reg [15:0] r;
      begin
         r = c ^ {8'h00, d};
         for (k = 0; k < 8; k = k + 1)
            r = r[0] ? ((r >> 1) ^ `MRS_CRC_POLY) : (r >> 1);
         crc_byte = r;
      end
   endfunction

   reg [2:0] state;
   reg [7:0] cnt;
   reg [7:0] fc;
   reg [15:0] start;
   reg [15:0] qty;
   reg [15:0] rx_crc;
   reg [7:0] b1;
   reg bad;
   reg [15:0] mw_v;
   reg [15:0] mw_i;
   reg mw_hv;
   reg mw_hi;
   reg [7:0] tx_idx;
   reg [7:0] tx_len;
   reg [15:0] tx_crc;
   reg [7:0] tx_sent;
   reg [7:0] fifo_din;
   reg fifo_wv;
   wire fifo_wr_ready;
   wire [7:0] fifo_dout;
   wire fifo_rv;
   wire fifo_take = fifo_rv && (!tx_valid_out || tx_ready_in);
   reg [7:0] next_byte;
   reg [7:0] rd_off;
   reg [15:0] rd_addr;
   reg [15:0] rd_word;
   wire crc_ok = (rx_crc == 16'h0000);
   wire [7:0] byte_cnt = {qty[6:0], 1'b0};

   mrs_fifo #(.WIDTH(8), .DEPTH(`MRS_FIFO_DEPTH), .AW(`MRS_FIFO_AW)) u_fifo (
      .core_clk_in(core_clk_in),
      .rstn_in(rstn_in),
      .wr_data_in(fifo_din),
      .wr_valid_in(fifo_wv),
      .wr_ready_out(fifo_wr_ready),
      .rd_data_out(fifo_dout),
      .rd_valid_out(fifo_rv),
      .rd_ready_in(tx_valid_out ? tx_ready_in : 1'b1)
   );

   // Register read mux: setpoints and display values
   always @*
   begin
      rd_off = tx_idx - 8'd3;
      rd_addr = start + {9'h000, rd_off[7:1]};
      case (rd_addr)
         `MRS_REG_VSET: rd_word = vset_out;
         `MRS_REG_ISET: rd_word = iset_out;
         `MRS_REG_VOUT: rd_word = vout_disp_in;
         `MRS_REG_IOUT: rd_word = iout_disp_in;
         default: rd_word = 16'h0000;
      endcase
   end

   // Reply byte selection, data high byte first
   always @*
   begin
      next_byte = 8'h00;
      if (tx_idx == 8'd0)
         next_byte = slave_addr_in;
      else if (tx_idx == 8'd1)
         next_byte = fc;
      else if (fc == `MRS_FC_READ)
      begin
         if (tx_idx == 8'd2)
            next_byte = byte_cnt;
         else
            next_byte = tx_idx[0] ? rd_word[15:8] : rd_word[7:0];
      end
      else
      begin
         case (tx_idx)
            8'd2: next_byte = start[15:8];
            8'd3: next_byte = start[7:0];
            8'd4: next_byte = qty[15:8];
            default: next_byte = qty[7:0];
         endcase
      end
   end

   always @(posedge core_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         state <= S_RX;
         cnt <= 8'h00;
         fc <= 8'h00;
         start <= 16'h0000;
         qty <= 16'h0000;
         rx_crc <= `MRS_CRC_INIT;
         b1 <= 8'h00;
         bad <= 1'b0;
         tx_sent <= 8'h00;
         tx_idx <= 8'h00;
         tx_len <= 8'h00;
         tx_crc <= `MRS_CRC_INIT;
         fifo_din <= 8'h00;
         fifo_wv <= 1'b0;
         rx_ready_out <= 1'b0;
         tx_data_out <= 8'h00;
         tx_valid_out <= 1'b0;
         tx_last_out <= 1'b0;
         vset_out <= `MRS_VSET_RST;
         iset_out <= `MRS_ISET_RST;
      end
      else
      begin
         fifo_wv <= 1'b0;
         if (fifo_take)
         begin
            tx_data_out <= fifo_dout;
            tx_valid_out <= 1'b1;
            tx_sent <= tx_sent + 8'd1;
            tx_last_out <= (tx_sent == tx_len + 8'd1);
         end
         else if (tx_ready_in)
         begin
            tx_valid_out <= 1'b0;
            tx_last_out <= 1'b0;
         end
         case (state)
            S_RX:
            begin
               rx_ready_out <= 1'b1;
               if (rx_valid_in && rx_ready_out)
               begin
                  // CRC over data plus check bytes leaves zero
                  rx_crc <= crc_byte(rx_crc, rx_data_in);
                  cnt <= cnt + 8'd1;
                  b1 <= rx_data_in;
                  case (cnt)
                     8'd0: if (rx_data_in != slave_addr_in) bad <= 1'b1;
                     8'd1: fc <= rx_data_in;
                     8'd2: start[15:8] <= rx_data_in;
                     8'd3: start[7:0] <= rx_data_in;
                     8'd4: qty[15:8] <= rx_data_in;
                     8'd5: qty[7:0] <= rx_data_in;
                     default: ;
                  endcase
               end
               if (rx_frame_end_in)
               begin
                  rx_ready_out <= 1'b0;
                  state <= S_CHK;
               end
            end
            S_CHK:
            begin
               tx_idx <= 8'h00;
               tx_crc <= `MRS_CRC_INIT;
               tx_sent <= 8'h00;
               if (bad || !crc_ok)
                  state <= S_DROP;
               else if (fc == `MRS_FC_READ && cnt == 8'd8 && qty != 16'h0
                        && qty <= 16'd32)
               begin
                  tx_len <= byte_cnt + 8'd3;
                  state <= S_HDR;
               end
               else if (fc == `MRS_FC_WR1 && cnt == 8'd8)
               begin
                  if (start == `MRS_REG_VSET)
                     vset_out <= qty;
                  else if (start == `MRS_REG_ISET)
                     iset_out <= qty;
                  tx_len <= 8'd6;
                  state <= S_HDR;
               end
               else if (fc == `MRS_FC_WRN && cnt == byte_cnt + 8'd9
                        && qty != 16'h0 && qty <= 16'd32)
               begin
                  if (mw_hv)
                     vset_out <= mw_v;
                  if (mw_hi)
                     iset_out <= mw_i;
                  tx_len <= 8'd6;
                  state <= S_HDR;
               end
               else
                  state <= S_DROP;
            end
            S_HDR:
            begin
               if (fifo_wr_ready && !fifo_wv)
               begin
                  fifo_din <= next_byte;
                  fifo_wv <= 1'b1;
                  tx_crc <= crc_byte(tx_crc, next_byte);
                  tx_idx <= tx_idx + 8'd1;
                  if (tx_idx + 8'd1 == tx_len)
                     state <= S_CRC;
               end
            end
            S_CRC:
            begin
               if (fifo_wr_ready && !fifo_wv)
               begin
                  fifo_wv <= 1'b1;
                  tx_idx <= tx_idx + 8'd1;
                  if (tx_idx == tx_len)
                     fifo_din <= tx_crc[7:0];
                  else
                  begin
                     fifo_din <= tx_crc[15:8];
                     state <= S_DROP;
                  end
               end
            end
            default:
            begin
               cnt <= 8'h00;
               bad <= 1'b0;
               rx_crc <= `MRS_CRC_INIT;
               state <= S_RX;
            end
         endcase
      end
   end

   // Multi-write payload: stored per word in a side buffer, applied post-check
   always @(posedge core_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         mw_v <= 16'h0000;
         mw_i <= 16'h0000;
         mw_hv <= 1'b0;
         mw_hi <= 1'b0;
      end
      else if (state == S_RX && rx_valid_in && rx_ready_out && cnt >= 8'd8
               && !cnt[0] && (cnt < byte_cnt + 8'd7))
      begin
         // Word index from byte position, successive addresses
         if (start + {9'h000, cnt[7:1]} - 16'd4 == `MRS_REG_VSET)
         begin
            mw_v <= {b1, rx_data_in};
            mw_hv <= 1'b1;
         end
         else if (start + {9'h000, cnt[7:1]} - 16'd4 == `MRS_REG_ISET)
         begin
            mw_i <= {b1, rx_data_in};
            mw_hi <= 1'b1;
         end
      end
      else if (state == S_DROP)
      begin
         mw_hv <= 1'b0;
         mw_hi <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ### inc/mrs_consts.vh
// Constants for the serial register-access frame handler
// Function
// - Read reply: address, 03, byte count twice registers, data, CRC.
// - Register data returned two bytes each, ascending from start address.
// - Register 0002H reads output voltage display, 0003H output current display.
// - Single write reply echoes address, 06H, register address, value, CRC.
// - Multi write reply: address, 10H, start address, quantity, CRC.
// - Register 0000H voltage setpoint, 0001H current setpoint, successive words.
// - Every reply starts with own address then the request's function code.
// - Sender appends final CRC register contents as two-byte check field.
// - CRC preset all ones, byte XORed in, eight conditional right shifts.
`ifndef MRS_CONSTS_VH
`define MRS_CONSTS_VH
`define MRS_FC_READ 8'h03
`define MRS_FC_WR1 8'h06
`define MRS_FC_WRN 8'h10
`define MRS_CRC_INIT 16'hFFFF
`define MRS_CRC_POLY 16'hA001
`define MRS_REG_VSET 16'h0000
`define MRS_REG_ISET 16'h0001
`define MRS_REG_VOUT 16'h0002
`define MRS_REG_IOUT 16'h0003
`define MRS_VSET_RST 16'h0000
`define MRS_ISET_RST 16'h0000
`define MRS_FIFO_DEPTH 32
`define MRS_FIFO_AW 5
`endif

// ### verilog/mrs_fifo.v
// Byte FIFO between the frame decoder and the reply path
`timescale 1ns/1ps
`default_nettype none
module mrs_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 32,
   parameter AW = 5
)(
   input wire core_clk_in,
   input wire rstn_in,
   input wire [WIDTH-1:0] wr_data_in,
   input wire wr_valid_in,
   output wire wr_ready_out,
   output reg [WIDTH-1:0] rd_data_out,
   output reg rd_valid_out,
   input wire rd_ready_in
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0] wp;
   reg [AW:0] rp;
   wire full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
   wire empty = (wp == rp);
   wire do_wr = wr_valid_in && !full;
   // Output register refills whenever empty or being taken
   wire do_rd = !empty && (!rd_valid_out || rd_ready_in);
   assign wr_ready_out = !full;
   always @(posedge core_clk_in)
   begin
      if (do_wr)
         mem[wp[AW-1:0]] <= wr_data_in;
   end
   always @(posedge core_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         wp <= {(AW+1){1'b0}};
         rp <= {(AW+1){1'b0}};
         rd_data_out <= {WIDTH{1'b0}};
         rd_valid_out <= 1'b0;
      end
      else
      begin
         if (do_wr)
            wp <= wp + 1'b1;
         if (do_rd)
         begin
            rd_data_out <= mem[rp[AW-1:0]];
            rp <= rp + 1'b1;
            rd_valid_out <= 1'b1;
         end
         else if (rd_ready_in)
            rd_valid_out <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ### test/mrs_slave_chk.sv
// Port checker for the frame handler, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module mrs_slave_chk (
   input wire logic core_clk_in,
   input wire logic rstn_in,
   input wire logic [7:0] slave_addr_in,
   input wire logic [15:0] vout_disp_in,
   input wire logic [15:0] iout_disp_in,
   input wire logic [7:0] rx_data_in,
   input wire logic rx_valid_in,
   input wire logic rx_frame_end_in,
   input wire logic rx_ready_out,
   input wire logic [7:0] tx_data_out,
   input wire logic tx_valid_out,
   input wire logic tx_ready_in,
   input wire logic tx_last_out,
   input wire logic [15:0] vset_out,
   input wire logic [15:0] iset_out
);
   logic [7:0] rxb [0:7];
   logic [3:0] rxn;
   logic [4:0] txn;
   logic [4:0] since_end;
   logic fresh;
   default clocking @(posedge core_clk_in);
   endclocking
   default disable iff (!rstn_in);
   // Only the first eight request bytes are kept; enough for echoes
   always @(posedge core_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         rxn <= 4'h0;
         txn <= 5'h00;
         fresh <= 1'b1;
         since_end <= 5'h1f;
      end
      else
      begin
         if (rx_frame_end_in)
         begin
            fresh <= 1'b1;
            txn <= 5'h00;
            since_end <= 5'h00;
         end
         else
         begin
            if (tx_valid_out && tx_ready_in && txn != 5'h1f)
               txn <= txn + 5'h01;
            if (since_end != 5'h1f)
               since_end <= since_end + 5'h01;
         end
         if (rx_valid_in && rx_ready_out && (fresh || !rxn[3]))
         begin
            rxb[fresh ? 3'h0 : rxn[2:0]] <= rx_data_in;
            rxn <= fresh ? 4'h1 : rxn + 4'h1;
            fresh <= 1'b0;
         end
      end
   end
   sequence s_foreign;
      rx_frame_end_in && (rxb[0] != slave_addr_in);
   endsequence
   property p_hold;
      tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out);
   endproperty
   property p_addr;
      tx_valid_out && txn == 5'h00 |-> tx_data_out == slave_addr_in;
   endproperty
   property p_fc;
      tx_valid_out && txn == 5'h01 |-> tx_data_out == rxb[1];
   endproperty
   property p_echo6;
      tx_valid_out && rxb[1] == 8'h06 && txn < 5'h08
         |-> tx_data_out == rxb[txn[2:0]];
   endproperty
   property p_echo10;
      tx_valid_out && rxb[1] == 8'h10 && txn < 5'h06
         |-> tx_data_out == rxb[txn[2:0]];
   endproperty
   property p_count;
      tx_valid_out && rxb[1] == 8'h03 && txn == 5'h02
         |-> tx_data_out == {rxb[5][6:0], 1'b0};
   endproperty
   property p_vout;
      tx_valid_out && rxb[1] == 8'h03 && rxb[2] == 8'h00
         && rxb[3] == 8'h02 && txn == 5'h03
         |-> tx_data_out == vout_disp_in[15:8];
   endproperty
   property p_quiet;
      s_foreign |=> !tx_valid_out [*8];
   endproperty
   property p_set;
      $changed(vset_out) || $changed(iset_out) |-> since_end < 5'h10;
   endproperty
   a_hold: assert property (p_hold) else $error("reply byte moved");
   a_addr: assert property (p_addr) else $error("bad reply address");
   a_fc: assert property (p_fc) else $error("bad reply function");
   a_echo6: assert property (p_echo6) else $error("bad echo");
   a_echo10: assert property (p_echo10) else $error("bad header");
   a_count: assert property (p_count) else $error("bad count");
   a_vout: assert property (p_vout) else $error("bad voltage");
   a_quiet: assert property (p_quiet) else $error("foreign reply");
   a_set: assert property (p_set) else $error("stray setpoint");
endmodule
bind mrs_slave mrs_slave_chk chk (.core_clk_in, .rstn_in, .slave_addr_in,
   .vout_disp_in, .iout_disp_in, .rx_data_in, .rx_valid_in,
   .rx_frame_end_in, .rx_ready_out, .tx_data_out, .tx_valid_out,
   .tx_ready_in, .tx_last_out, .vset_out, .iset_out);
`default_nettype wire

// ### test/mrs_host_model.sv
// Host model: sends request frames, collects reply bytes
`timescale 1ns/1ps
`default_nettype none
module mrs_host_model (
   input wire logic core_clk_in,
   input wire logic rx_ready_in,
   output logic [7:0] rx_data_out,
   output logic rx_valid_out,
   output logic frame_end_out,
   input wire logic [7:0] tx_data_in,
   input wire logic tx_valid_in,
   output logic tx_ready_out,
   input wire logic tx_last_in
);
   logic [7:0] got[$];
   int stall = 0;
   int cyc = 0;
   int last_at = 0;
   initial
   begin
      rx_data_out = 8'h00;
      rx_valid_out = 1'b0;
      frame_end_out = 1'b0;
      tx_ready_out = 1'b1;
   end
   function automatic logic [15:0] crc16(input logic [7:0] f[$]);
      logic [15:0] c;
      c = 16'hffff;
      foreach (f[i])
      begin
         c = c ^ {8'h00, f[i]};
         repeat (8)
            c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
      end
      return c;
   endfunction
   // A spoiled check byte drives the silent drop path
   task automatic send(input logic [7:0] f[$], input bit good);
      logic [15:0] c;
      c = crc16(f);
      f.push_back(c[7:0] ^ {7'h00, !good});
      f.push_back(c[15:8]);
      foreach (f[i])
      begin
         rx_data_out <= f[i];
         rx_valid_out <= 1'b1;
         @(posedge core_clk_in);
         while (!rx_ready_in)
            @(posedge core_clk_in);
      end
      rx_valid_out <= 1'b0;
      rx_data_out <= ~f[f.size() - 1];
      frame_end_out <= 1'b1;
      @(posedge core_clk_in);
      frame_end_out <= 1'b0;
   endtask
   always @(posedge core_clk_in)
   begin
      if (tx_valid_in && tx_ready_out)
      begin
         got.push_back(tx_data_in);
         // Position of the byte flagged last, counted from one
         if (tx_last_in)
            last_at <= got.size();
      end
      cyc <= cyc + 1;
      tx_ready_out <= (stall == 0) || (cyc % stall == 0);
   end
endmodule
`default_nettype wire

// ### test/modbus_rtu_slave_frames_bench.sv
// Bench: read, single and multi write, dropped frames
`timescale 1ns/1ps
`default_nettype none
module modbus_rtu_slave_frames_bench;
   typedef logic [7:0] mrs_bytes_t[$];
   logic core_clk_in;
   logic rstn_in;
   logic [7:0] slave_addr;
   logic [15:0] vout_disp;
   logic [15:0] iout_disp;
   logic [7:0] rx_data;
   logic rx_valid;
   logic rx_end;
   logic rx_ready;
   logic [7:0] tx_data;
   logic tx_valid;
   logic tx_ready;
   logic tx_last;
   logic [15:0] vset;
   logic [15:0] iset;
   mrs_bytes_t f;
   int err_total = 0;
   int n_tests = 0;
   int cycles = 0;
   mrs_slave dut (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
      .slave_addr_in(slave_addr), .vout_disp_in(vout_disp),
      .iout_disp_in(iout_disp), .rx_data_in(rx_data),
      .rx_valid_in(rx_valid), .rx_frame_end_in(rx_end),
      .rx_ready_out(rx_ready), .tx_data_out(tx_data),
      .tx_valid_out(tx_valid), .tx_ready_in(tx_ready),
      .tx_last_out(tx_last),
      .vset_out(vset), .iset_out(iset));
   mrs_host_model host (.core_clk_in(core_clk_in), .rx_ready_in(rx_ready),
      .rx_data_out(rx_data), .rx_valid_out(rx_valid),
      .frame_end_out(rx_end), .tx_data_in(tx_data),
      .tx_valid_in(tx_valid), .tx_ready_out(tx_ready),
      .tx_last_in(tx_last));
   initial
   begin
      core_clk_in = 1'b0;
      forever
         #2.5 core_clk_in = ~core_clk_in;
   end
   task check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         err_total++;
         $display("ERROR %0t got %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic mrs_bytes_t hdr(input logic [7:0] fc,
      input logic [15:0] a, input logic [15:0] b);
      return '{slave_addr, fc, a[15:8], a[7:0], b[15:8], b[7:0]};
   endfunction
   task automatic expect_reply(input logic [7:0] e[$]);
      logic [15:0] c;
      c = host.crc16(e);
      e.push_back(c[7:0]);
      e.push_back(c[15:8]);
      repeat (300)
         if (host.got.size() < e.size())
            @(posedge core_clk_in);
      repeat (8)
         @(posedge core_clk_in);
      check(16'(host.got.size()), 16'(e.size()));
      foreach (e[i])
         check(16'(host.got[i]), 16'(e[i]));
      check(16'(host.last_at), 16'(e.size()));
      host.got.delete();
      host.last_at = 0;
   endtask
   task automatic expect_none;
      repeat (40)
         @(posedge core_clk_in);
      check(16'(host.got.size()), 16'h0000);
      check(16'(host.last_at), 16'h0000);
      check(vset, 16'h1234);
   endtask
   task automatic t_read;
      host.stall = 3;
      f = hdr(8'h03, 16'h0002, 16'h0002);
      check(host.crc16(f), 16'hcb65);
      host.send(f, 1'b1);
      expect_reply('{8'h01, 8'h03, 8'h04, 8'h01, 8'hf4, 8'h13, 8'h88});
      host.stall = 0;
   endtask
   task automatic t_write1;
      host.send(hdr(8'h06, 16'h0000, 16'h0960), 1'b1);
      expect_reply(hdr(8'h06, 16'h0000, 16'h0960));
      check(vset, 16'h0960);
      host.send(hdr(8'h06, 16'h0001, 16'h05dc), 1'b1);
      expect_reply(hdr(8'h06, 16'h0001, 16'h05dc));
      check(iset, 16'h05dc);
   endtask
   task automatic t_multi;
      f = {hdr(8'h10, 16'h0000, 16'h0002), 8'h04, 8'h12, 8'h34, 8'h56, 8'h78};
      host.send(f, 1'b1);
      expect_reply(hdr(8'h10, 16'h0000, 16'h0002));
      check(vset, 16'h1234);
      check(iset, 16'h5678);
      host.send(hdr(8'h03, 16'h0000, 16'h0004), 1'b1);
      expect_reply('{8'h01, 8'h03, 8'h08, 8'h12, 8'h34, 8'h56, 8'h78,
         8'h01, 8'hf4, 8'h13, 8'h88});
   endtask
   task automatic t_drop;
      f = hdr(8'h06, 16'h0000, 16'h0077);
      host.send(f, 1'b0);
      expect_none;
      f[0] = 8'h7e;
      host.send(f, 1'b1);
      expect_none;
      slave_addr <= 8'h7e;
      @(posedge core_clk_in);
      host.send(hdr(8'h03, 16'h0003, 16'h0001), 1'b1);
      expect_reply('{8'h7e, 8'h03, 8'h02, 8'h13, 8'h88});
   endtask
   task complete_run;
      if (err_total == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      rstn_in = 1'b0;
      slave_addr = 8'h01;
      vout_disp = 16'h01f4;
      iout_disp = 16'h1388;
      repeat (6)
         @(posedge core_clk_in);
      rstn_in <= 1'b1;
      repeat (3)
         @(posedge core_clk_in);
      t_read;
      t_write1;
      t_multi;
      t_drop;
      complete_run;
   end
   // Whole run needs a few hundred cycles; a hang ends here
   always @(posedge core_clk_in)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         err_total++;
         complete_run;
      end
   end
endmodule
`default_nettype wire
